// ### tlb_store.sv
// Shared constants and the physical page number store of the buffer
`timescale 1ns/10ps

package tlb_pkg;
  localparam int          VPN_W          = 20;
  localparam int          ADDRESS_SPACE_IDENTIFIER_W         = 8;
  localparam int          PPN_W          = 20;
  localparam int          AP_W           = 3;
  localparam int          DATA_W         = 32;
  localparam int          OPND_VPN_LSB   = 12;
  localparam int          OPND_ADDRESS_SPACE_IDENTIFIER_LSB  = 0;
  localparam int          RES_PPN_LSB    = 12;
  localparam int          RES_FAULT_BIT  = 0;
  localparam int          OP2_SECURE_BIT = 2;
  localparam logic [31:0] RES_RESET      = 32'h0000_0000;
  // Coprocessor decode
  localparam logic [2:0]  OP1_SYS        = 3'h0;
  localparam logic [3:0]  CRN_CACHE      = 4'h7;
  localparam logic [3:0]  CRN_MAINT      = 4'h8;
  localparam logic [3:0]  CRM_TRANSLATE  = 4'h8;
  localparam logic [3:0]  CRM_RESULT     = 4'h4;
  localparam logic [2:0]  OP2_RESULT     = 3'h0;
  localparam logic [3:0]  CRM_BCAST      = 4'h3;
  localparam logic [3:0]  CRM_ITLB       = 4'h5;
  localparam logic [3:0]  CRM_DTLB       = 4'h6;
  localparam logic [3:0]  CRM_UTLB       = 4'h7;
  // Maintenance selectors
  localparam logic [2:0]  OP2_INV_ALL    = 3'h0;
  localparam logic [2:0]  OP2_INV_ADDR   = 3'h1;
  localparam logic [2:0]  OP2_INV_SPACE  = 3'h2;
  localparam logic [2:0]  OP2_INV_ANY    = 3'h3;
  // Probe checks, low two selector bits
  localparam logic [1:0]  CHK_PRIV_RD    = 2'h0;
  localparam logic [1:0]  CHK_PRIV_WR    = 2'h1;
  localparam logic [1:0]  CHK_USER_RD    = 2'h2;
  localparam logic [1:0]  CHK_USER_WR    = 2'h3;
  // Entry access permission codes
  localparam logic [2:0]  AP_NONE        = 3'h0;
  localparam logic [2:0]  AP_PRIV        = 3'h1;
  localparam logic [2:0]  AP_USER_RO     = 3'h2;
  localparam logic [2:0]  AP_FULL        = 3'h3;
  localparam logic [2:0]  AP_PRIV_RO     = 3'h5;
  localparam logic [2:0]  AP_ALL_RO_A    = 3'h6;
  localparam logic [2:0]  AP_ALL_RO_B    = 3'h7;

  typedef enum logic [3:0] {
    ST_IDLE   = 4'b0001,
    ST_PROBE  = 4'b0010,
    ST_RESULT = 4'b0100,
    ST_SWEEP  = 4'b1000
  } state_t;
endpackage : tlb_pkg

module tlb_store
  import tlb_pkg::*;
#(
  parameter int ENTRIES = 16,
  parameter int IDX_W   = $clog2(ENTRIES)
) (
  input  wire logic             clk,
  input  wire logic             wr_en,
  input  wire logic [IDX_W-1:0] wr_idx,
  input  wire logic [PPN_W-1:0] wr_data,
  input  wire logic [IDX_W-1:0] rd_idx,
  output logic      [PPN_W-1:0] rd_data_r
);
  logic [PPN_W-1:0] mem [ENTRIES];

  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[wr_idx] <= wr_data;
    end
  end

  // Registered read keeps the probe path off the compare tree
  always_ff @(posedge clk) begin
    rd_data_r <= mem[rd_idx];
  end
endmodule : tlb_store

// ### tlb_maint.sv
// Buffer maintenance and address translation probe command logic
`timescale 1ns/10ps

module tlb_maint
  import tlb_pkg::*;
#(
  parameter int ENTRIES = 16,
  parameter int IDX_W   = $clog2(ENTRIES)
) (
  input  wire logic              CLOCK,
  input  wire logic              RESET_N,
  input  wire logic              CP_VALID,
  input  wire logic              CP_WRITE,
  input  wire logic [2:0]        CP_OP1,
  input  wire logic [3:0]        CP_CRN,
  input  wire logic [3:0]        CP_CRM,
  input  wire logic [2:0]        CP_OP2,
  input  wire logic [DATA_W-1:0] CP_WDATA,
  input  wire logic              PRIV_MODE,
  input  wire logic              SECURE,
  input  wire logic [ADDRESS_SPACE_IDENTIFIER_W-1:0] CONTEXT_ADDRESS_SPACE_IDENTIFIER,
  input  wire logic              IRQ_PENDING,
  input  wire logic              FILL_VALID,
  input  wire logic [IDX_W-1:0]  FILL_INDEX,
  input  wire logic [VPN_W-1:0]  FILL_VPN,
  input  wire logic [ADDRESS_SPACE_IDENTIFIER_W-1:0] FILL_ADDRESS_SPACE_IDENTIFIER,
  input  wire logic [PPN_W-1:0]  FILL_PPN,
  input  wire logic [AP_W-1:0]   FILL_AP,
  input  wire logic              FILL_GLOBAL,
  input  wire logic              FILL_LOCK,
  output logic                   BUSY,
  output logic                   CP_DONE,
  output logic                   CP_UNDEF,
  output logic                   CP_RESTART,
  output logic      [DATA_W-1:0] CP_RDATA,
  output logic      [DATA_W-1:0] PA_RESULT,
  output logic                   BCAST_VALID,
  output logic      [2:0]        BCAST_OP,
  output logic      [DATA_W-1:0] BCAST_DATA
);
  state_t            state_r;
  logic [IDX_W-1:0]  sweep_idx_r;
  logic [ADDRESS_SPACE_IDENTIFIER_W-1:0] sweep_address_space_identifier_r;
  logic [VPN_W-1:0]  probe_vpn_r;
  logic [ADDRESS_SPACE_IDENTIFIER_W-1:0] probe_address_space_identifier_r;
  logic [1:0]        probe_chk_r;
  logic              probe_hit_r;
  logic              probe_ok_r;
  logic [IDX_W-1:0]  probe_idx_r;
  logic [PPN_W-1:0]  ppn_rd;

  logic [ENTRIES-1:0] valid_r;
  logic [ENTRIES-1:0] lock_r;
  logic [ENTRIES-1:0] glob_r;
  logic [VPN_W-1:0]   vpn_r  [ENTRIES];
  logic [ADDRESS_SPACE_IDENTIFIER_W-1:0]  address_space_identifier_r [ENTRIES];
  logic [AP_W-1:0]    ap_r   [ENTRIES];

  logic              take;
  logic              in_space;
  logic              is_result;
  logic              is_trans;
  logic              is_maint;
  logic              maint_crm_ok;
  logic              undef;
  logic              do_all;
  logic              do_addr;
  logic              do_any;
  logic              start_sweep;
  logic              start_probe;
  logic [VPN_W-1:0]  op_vpn;
  logic [ADDRESS_SPACE_IDENTIFIER_W-1:0] op_address_space_identifier;
  logic              sweep_last;
  logic              sweep_abort;
  logic [ENTRIES-1:0] hit_vec;
  logic              hit_any;
  logic [IDX_W-1:0]  hit_idx;

  // Commands are taken only while idle; the pipeline holds until BUSY drops
  assign take     = CP_VALID && (state_r == ST_IDLE);
  assign in_space = (CP_OP1 == OP1_SYS) &&
                    ((CP_CRN == CRN_MAINT) || (CP_CRN == CRN_CACHE &&
                     (CP_CRM == CRM_TRANSLATE || CP_CRM == CRM_RESULT)));
  assign is_result = (CP_CRN == CRN_CACHE) && (CP_CRM == CRM_RESULT) &&
                     (CP_OP2 == OP2_RESULT);
  assign is_trans  = (CP_CRN == CRN_CACHE) && (CP_CRM == CRM_TRANSLATE);
  assign is_maint  = (CP_CRN == CRN_MAINT);

  // Instruction and data scopes alias the unified buffer
  assign maint_crm_ok = (CP_CRM == CRM_BCAST) || (CP_CRM == CRM_ITLB) ||
                        (CP_CRM == CRM_DTLB)  || (CP_CRM == CRM_UTLB);

  // User access, or any read except the result register, traps
  assign undef = take && in_space &&
                 (!PRIV_MODE ||
                  (!CP_WRITE && !is_result));

  // Operand split: page in the upper bits, identifier in the low byte
  assign op_vpn  = CP_WDATA[OPND_VPN_LSB +: VPN_W];
  assign op_address_space_identifier = CP_WDATA[OPND_ADDRESS_SPACE_IDENTIFIER_LSB +: ADDRESS_SPACE_IDENTIFIER_W];

  // Undefined selector/scope pairs simply complete with no effect
  always_comb begin
    do_all      = 1'b0;
    do_addr     = 1'b0;
    do_any      = 1'b0;
    start_sweep = 1'b0;
    start_probe = 1'b0;
    if (take && !undef && CP_WRITE && in_space) begin
      if (is_maint && maint_crm_ok) begin
        case (CP_OP2)
          OP2_INV_ALL:   do_all      = 1'b1;
          OP2_INV_ADDR:  do_addr     = 1'b1;
          OP2_INV_SPACE: start_sweep = 1'b1;
          OP2_INV_ANY:   do_any      = 1'b1;
          default: begin
          end
        endcase
      end else if (is_trans) begin
        start_probe = 1'b1;
      end
    end
  end

  assign sweep_last  = (sweep_idx_r == IDX_W'(ENTRIES - 1));
  assign sweep_abort = (state_r == ST_SWEEP) && IRQ_PENDING;

  // Per-entry state; all, address and any invalidations land in the command cycle, sweep kills at most one entry per sweep cycle
  genvar gi;
  generate
    for (gi = 0; gi < ENTRIES; gi++) begin : g_entry
      logic va_hit;
      logic id_hit;
      logic kill;
      assign va_hit = (vpn_r[gi] == op_vpn);
      assign id_hit = (address_space_identifier_r[gi] == op_address_space_identifier);
      assign kill =
        (do_all && !lock_r[gi]) ||
        (do_addr && va_hit && (glob_r[gi] || id_hit) &&
         !lock_r[gi]) ||
        (do_any && va_hit && !lock_r[gi]) ||
        ((state_r == ST_SWEEP) && !sweep_abort &&
         (sweep_idx_r == IDX_W'(gi)) &&
         (address_space_identifier_r[gi] == sweep_address_space_identifier_r) &&
         !glob_r[gi]);

      always_ff @(posedge CLOCK) begin
        if (!RESET_N) begin
          valid_r[gi] <= 1'b0;
        end else if (FILL_VALID && FILL_INDEX == IDX_W'(gi)) begin
          valid_r[gi] <= 1'b1;
        end else if (kill) begin
          valid_r[gi] <= 1'b0;
        end
      end

      always_ff @(posedge CLOCK) begin
        if (!RESET_N) begin
          lock_r[gi] <= 1'b0;
          glob_r[gi] <= 1'b0;
          vpn_r[gi]  <= '0;
          address_space_identifier_r[gi] <= '0;
          ap_r[gi]   <= AP_NONE;
        end else if (FILL_VALID && FILL_INDEX == IDX_W'(gi)) begin
          lock_r[gi] <= FILL_LOCK;
          glob_r[gi] <= FILL_GLOBAL;
          vpn_r[gi]  <= FILL_VPN;
          address_space_identifier_r[gi] <= FILL_ADDRESS_SPACE_IDENTIFIER;
          ap_r[gi]   <= FILL_AP;
        end
      end

      // Probe matches under the current context identifier
      assign hit_vec[gi] = valid_r[gi] && (vpn_r[gi] == probe_vpn_r) &&
                           (glob_r[gi] ||
                            address_space_identifier_r[gi] == probe_address_space_identifier_r);
    end
  endgenerate

  // Lowest matching entry wins
  always_comb begin
    hit_any = 1'b0;
    hit_idx = '0;
    for (int i = ENTRIES - 1; i >= 0; i--) begin
      if (hit_vec[i]) begin
        hit_any = 1'b1;
        hit_idx = IDX_W'(i);
      end
    end
  end

  function automatic logic perm_ok(input logic [AP_W-1:0] ap,
                                   input logic [1:0]      chk);
    logic user;
    logic wr;
    user = (chk == CHK_USER_RD) || (chk == CHK_USER_WR);
    wr   = (chk == CHK_PRIV_WR) || (chk == CHK_USER_WR);
    case (ap)
      AP_PRIV:     perm_ok = !user;
      AP_USER_RO:  perm_ok = !user || !wr;
      AP_FULL:     perm_ok = 1'b1;
      AP_PRIV_RO:  perm_ok = !user && !wr;
      AP_ALL_RO_A: perm_ok = !wr;
      AP_ALL_RO_B: perm_ok = !wr;
      default:     perm_ok = 1'b0;
    endcase
  endfunction : perm_ok

  tlb_store #(
    .ENTRIES (ENTRIES),
    .IDX_W   (IDX_W)
  ) u_store (
    .clk       (CLOCK),
    .wr_en     (FILL_VALID),
    .wr_idx    (FILL_INDEX),
    .wr_data   (FILL_PPN),
    .rd_idx    (hit_idx),
    .rd_data_r (ppn_rd)
  );

  // Sequencer
  always_ff @(posedge CLOCK) begin
    if (!RESET_N) begin
      state_r <= ST_IDLE;
    end else begin
      case (state_r)
        ST_IDLE: begin
          if (start_probe) begin
            state_r <= ST_PROBE;
          end else if (start_sweep) begin
            state_r <= ST_SWEEP;
          end
        end
        ST_PROBE:  state_r <= ST_RESULT;
        ST_RESULT: state_r <= ST_IDLE;
        ST_SWEEP: begin
          if (sweep_abort || sweep_last) begin
            state_r <= ST_IDLE;
          end
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  // Sweep always begins at entry 0, so a re-executed command also
  // catches entries refilled during the interrupt
  always_ff @(posedge CLOCK) begin
    if (!RESET_N) begin
      sweep_idx_r  <= '0;
      sweep_address_space_identifier_r <= '0;
    end else if (start_sweep) begin
      sweep_idx_r  <= '0;
      sweep_address_space_identifier_r <= op_address_space_identifier;
    end else if (state_r == ST_SWEEP && !sweep_abort) begin
      sweep_idx_r  <= sweep_idx_r + IDX_W'(1);
    end
  end

  // Probe capture; bit 2 of the selector is not used, only bits 1:0 are kept as the check
  always_ff @(posedge CLOCK) begin
    if (!RESET_N) begin
      probe_vpn_r  <= '0;
      probe_address_space_identifier_r <= '0;
      probe_chk_r  <= CHK_PRIV_RD;
    end else if (start_probe) begin
      probe_vpn_r  <= op_vpn;
      probe_address_space_identifier_r <= CONTEXT_ADDRESS_SPACE_IDENTIFIER;
      // Same check set in both states; SECURE is not read anywhere in the block
      probe_chk_r  <= CP_OP2[1:0];
    end
  end

  always_ff @(posedge CLOCK) begin
    if (!RESET_N) begin
      probe_hit_r <= 1'b0;
      probe_ok_r  <= 1'b0;
      probe_idx_r <= '0;
    end else if (state_r == ST_PROBE) begin
      probe_hit_r <= hit_any;
      probe_ok_r  <= perm_ok(ap_r[hit_idx], probe_chk_r);
      probe_idx_r <= hit_idx;
    end
  end

  // Result register: page number above, fault flag in bit 0
  always_ff @(posedge CLOCK) begin
    if (!RESET_N) begin
      PA_RESULT <= RES_RESET;
    end else if (state_r == ST_RESULT) begin
      PA_RESULT <= RES_RESET;
      if (probe_hit_r) begin
        PA_RESULT[RES_PPN_LSB +: PPN_W] <= ppn_rd;
      end
      PA_RESULT[RES_FAULT_BIT] <= !(probe_hit_r && probe_ok_r);
    end
  end

  always_ff @(posedge CLOCK) begin
    if (!RESET_N) begin
      CP_RDATA <= '0;
    end else if (take && !undef && !CP_WRITE && is_result) begin
      CP_RDATA <= PA_RESULT;
    end
  end

  // Completion and trap pulses
  always_ff @(posedge CLOCK) begin
    if (!RESET_N) begin
      CP_DONE    <= 1'b0;
      CP_UNDEF   <= 1'b0;
      CP_RESTART <= 1'b0;
    end else begin
      CP_UNDEF   <= undef;
      CP_RESTART <= sweep_abort;
      CP_DONE    <= (take && !undef && !start_probe && !start_sweep) ||
                    (state_r == ST_RESULT) ||
                    (state_r == ST_SWEEP && !sweep_abort && sweep_last);
    end
  end

  // Held high while a multi-cycle command owns the buffer; fetch flush
  // must wait on it so no stale entry survives the flush
  always_ff @(posedge CLOCK) begin
    if (!RESET_N) begin
      BUSY <= 1'b0;
    end else begin
      BUSY <= start_probe || start_sweep ||
              (state_r == ST_PROBE) ||
              (state_r == ST_SWEEP && !sweep_abort && !sweep_last);
    end
  end

  // Broadcast scope is also performed locally
  always_ff @(posedge CLOCK) begin
    if (!RESET_N) begin
      BCAST_VALID <= 1'b0;
      BCAST_OP    <= OP2_INV_ALL;
      BCAST_DATA  <= '0;
    end else begin
      BCAST_VALID <= (do_all || do_addr || do_any || start_sweep) &&
                     (CP_CRM == CRM_BCAST);
      if (take && CP_WRITE) begin
        BCAST_OP   <= CP_OP2;
        BCAST_DATA <= CP_WDATA;
      end
    end
  end
endmodule : tlb_maint

// ### tlb_maint_asserts.sv
// Protocol checker for the maintenance and translation command block
`timescale 1ns/10ps

module tlb_maint_checker
  import tlb_pkg::*;
#(
  parameter int ENTRIES = 16
) (
  input wire logic              CLOCK,
  input wire logic              RESET_N,
  input wire logic              CP_VALID,
  input wire logic              CP_WRITE,
  input wire logic [2:0]        CP_OP1,
  input wire logic [3:0]        CP_CRN,
  input wire logic [3:0]        CP_CRM,
  input wire logic [2:0]        CP_OP2,
  input wire logic [DATA_W-1:0] CP_WDATA,
  input wire logic              PRIV_MODE,
  input wire logic              IRQ_PENDING,
  input wire logic              BUSY,
  input wire logic              CP_DONE,
  input wire logic              CP_UNDEF,
  input wire logic              CP_RESTART,
  input wire logic [DATA_W-1:0] PA_RESULT,
  input wire logic              BCAST_VALID,
  input wire logic [2:0]        BCAST_OP,
  input wire logic [DATA_W-1:0] BCAST_DATA
);
  default clocking @(posedge CLOCK); endclocking
  default disable iff (!RESET_N);

  wire tk  = CP_VALID && !BUSY && (CP_OP1 == OP1_SYS);
  wire mnt = tk && (CP_CRN == CRN_MAINT);
  wire mwr = mnt && CP_WRITE && PRIV_MODE;
  wire prb = tk && CP_WRITE && (CP_CRN == CRN_CACHE)
             && (CP_CRM == CRM_TRANSLATE);
  wire lcl = (CP_CRM == CRM_ITLB) || (CP_CRM == CRM_DTLB)
             || (CP_CRM == CRM_UTLB);

  a_user_maint_undef: assert property (
      mnt && !PRIV_MODE |=> CP_UNDEF)
    else $error("user maintenance write not trapped");
  a_maint_read_undef: assert property (
      mnt && !CP_WRITE |=> CP_UNDEF && !CP_DONE)
    else $error("maintenance read not trapped");
  a_user_probe_undef: assert property (
      prb && !PRIV_MODE |=> CP_UNDEF && !BUSY)
    else $error("user probe not trapped");
  a_user_probe_quiet: assert property (
      prb && !PRIV_MODE |=> $stable(PA_RESULT)[*2])
    else $error("user probe changed result");
  a_probe_ns_done: assert property (
      prb && PRIV_MODE && !CP_OP2[2] |=> BUSY ##[1:4] CP_DONE)
    else $error("probe with low selector not completed");
  a_probe_sec_done: assert property (
      prb && PRIV_MODE && CP_OP2[2] |=> BUSY ##[1:4] CP_DONE)
    else $error("probe with high selector not completed");
  a_result_by_probe: assert property (
      !$stable(PA_RESULT) |-> $past(BUSY))
    else $error("result changed outside a probe");
  a_bcast_echo: assert property (
      mwr && CP_CRM == CRM_BCAST && !CP_OP2[2] && CP_OP2 != OP2_INV_SPACE
      |=> CP_DONE && BCAST_VALID && BCAST_OP == $past(CP_OP2)
      && BCAST_DATA == $past(CP_WDATA))
    else $error("broadcast request missing or wrong");
  a_local_no_bcast: assert property (
      mwr && lcl && CP_OP2 == OP2_INV_ALL |=> CP_DONE && !BCAST_VALID)
    else $error("local operation broadcast or not done");
  a_sweep_busy: assert property (
      mwr && lcl && CP_OP2 == OP2_INV_SPACE |=> BUSY && !CP_DONE)
    else $error("identifier sweep finished at once");
  a_restart_cause: assert property (
      CP_RESTART |-> $past(IRQ_PENDING) || $past(IRQ_PENDING, 2))
    else $error("restart without pending interrupt");

  c_probe: cover property (prb && PRIV_MODE ##[1:5] CP_DONE);
  c_restart: cover property (CP_RESTART);
  c_bcast: cover property (BCAST_VALID);
endmodule : tlb_maint_checker

bind tlb_maint tlb_maint_checker #(.ENTRIES(ENTRIES)) u_chk (
  .CLOCK(CLOCK), .RESET_N(RESET_N), .CP_VALID(CP_VALID),
  .CP_WRITE(CP_WRITE), .CP_OP1(CP_OP1), .CP_CRN(CP_CRN), .CP_CRM(CP_CRM),
  .CP_OP2(CP_OP2), .CP_WDATA(CP_WDATA), .PRIV_MODE(PRIV_MODE),
  .IRQ_PENDING(IRQ_PENDING), .BUSY(BUSY), .CP_DONE(CP_DONE),
  .CP_UNDEF(CP_UNDEF), .CP_RESTART(CP_RESTART), .PA_RESULT(PA_RESULT),
  .BCAST_VALID(BCAST_VALID), .BCAST_OP(BCAST_OP), .BCAST_DATA(BCAST_DATA));

// ### cp_core_model.sv
// Core pipeline model issuing coprocessor transfers
`timescale 1ns/10ps

module cp_core_model (
  input  wire logic   clock,
  input  wire logic   busy,
  input  wire logic   cp_done,
  input  wire logic   cp_undef,
  input  wire logic   cp_restart,
  output logic        cp_valid,
  output logic        cp_write,
  output logic [2:0]  cp_op1,
  output logic [3:0]  cp_crn,
  output logic [3:0]  cp_crm,
  output logic [2:0]  cp_op2,
  output logic [31:0] cp_wdata,
  output logic        priv_mode
);
  initial begin
    cp_valid  = 1'b0;
    cp_write  = 1'b0;
    cp_op1    = 3'h0;
    cp_crn    = 4'h0;
    cp_crm    = 4'h0;
    cp_op2    = 3'h0;
    cp_wdata  = 32'h0;
    priv_mode = 1'b1;
  end

  // Answer: 1 done, 2 trap, 3 restart, 0 no answer within bound
  task automatic issue(input logic wr, input logic [3:0] crn, minor_register_field,
                       input logic [2:0] op2, input logic [31:0] d,
                       input logic pv, output logic [1:0] ans);
    int n;
    ans = 2'h0;
    @(posedge clock);
    #1;
    cp_valid  = 1'b1;
    cp_write  = wr;
    cp_crn    = crn;
    cp_crm    = minor_register_field;
    cp_op2    = op2;
    cp_wdata  = d;
    priv_mode = pv;
    // Held until an edge sees the block idle
    for (n = 0; n < 64 && busy !== 1'b0; n++) begin
      @(posedge clock);
      #1;
    end
    @(posedge clock);
    #1;
    // Released fields do not keep their old value
    cp_valid = 1'b0;
    cp_crn   = ~crn;
    cp_crm   = ~minor_register_field;
    cp_op2   = ~op2;
    cp_wdata = ~d;
    for (n = 0; n < 64 && ans == 2'h0; n++) begin
      if (n > 0) begin
        @(posedge clock);
        #1;
      end
      if (cp_done === 1'b1) ans = 2'h1;
      else if (cp_undef === 1'b1) ans = 2'h2;
      else if (cp_restart === 1'b1) ans = 2'h3;
    end
  endtask : issue
endmodule : cp_core_model

// ### tlb_maintenance_and_va_translate_tb.sv
// Self-checking bench for the maintenance and translation block
`timescale 1ns/10ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin \
  bad_count++; $display("unexpected %s exp %h got %h", nm, e, g); end end

module tlb_maintenance_and_va_translate_tb;
  import tlb_pkg::*;
  logic        clk, reset_n, cp_valid, cp_write, priv_mode, secure, irq;
  logic        fill_valid, fill_global, fill_lock, busy, cp_done, cp_undef;
  logic        cp_restart, bcast_valid;
  logic [2:0]  cp_op1, cp_op2, fill_ap, bcast_op;
  logic [3:0]  cp_crn, cp_crm, fill_index;
  logic [7:0]  context_address_space_identifier, fill_address_space_identifier;
  logic [19:0] fill_vpn, fill_ppn;
  logic [31:0] cp_wdata, cp_rdata, pa_result, bcast_data, seed, opnd;
  logic [20:0] exp_pa;
  int          bad_count, n_compared, bcast_cnt, b0;
  localparam logic [2:0] T_OP [5] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h3};
  localparam int         T_K [5] = '{0, 0, 0, 3, 1};
  localparam logic [3:0] T_KEEP [5] = '{4'h2, 4'he, 4'hc, 4'h7, 4'hf};
  localparam logic [3:0] CRMS [4] = '{CRM_BCAST, CRM_ITLB, CRM_DTLB, CRM_UTLB};

  tlb_maint #(.ENTRIES(16)) dut (
    .CLOCK(clk), .RESET_N(reset_n), .CP_VALID(cp_valid),
    .CP_WRITE(cp_write), .CP_OP1(cp_op1), .CP_CRN(cp_crn), .CP_CRM(cp_crm),
    .CP_OP2(cp_op2), .CP_WDATA(cp_wdata), .PRIV_MODE(priv_mode),
    .SECURE(secure), .CONTEXT_ADDRESS_SPACE_IDENTIFIER(context_address_space_identifier), .IRQ_PENDING(irq),
    .FILL_VALID(fill_valid), .FILL_INDEX(fill_index), .FILL_VPN(fill_vpn),
    .FILL_ADDRESS_SPACE_IDENTIFIER(fill_address_space_identifier), .FILL_PPN(fill_ppn), .FILL_AP(fill_ap),
    .FILL_GLOBAL(fill_global), .FILL_LOCK(fill_lock), .BUSY(busy),
    .CP_DONE(cp_done), .CP_UNDEF(cp_undef), .CP_RESTART(cp_restart),
    .CP_RDATA(cp_rdata), .PA_RESULT(pa_result), .BCAST_VALID(bcast_valid),
    .BCAST_OP(bcast_op), .BCAST_DATA(bcast_data));

  cp_core_model core (
    .clock(clk), .busy(busy), .cp_done(cp_done), .cp_undef(cp_undef),
    .cp_restart(cp_restart), .cp_valid(cp_valid), .cp_write(cp_write),
    .cp_op1(cp_op1), .cp_crn(cp_crn), .cp_crm(cp_crm), .cp_op2(cp_op2),
    .cp_wdata(cp_wdata), .priv_mode(priv_mode));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  always @(posedge clk) if (bcast_valid === 1'b1) bcast_cnt++;

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  function automatic logic perm_fault(input logic [2:0] ap,
                                      input logic [1:0] chk);
    case (ap)
      AP_PRIV:                  return chk[1];
      AP_USER_RO:               return chk[1] & chk[0];
      AP_FULL:                  return 1'b0;
      AP_PRIV_RO:               return chk[1] | chk[0];
      AP_ALL_RO_A, AP_ALL_RO_B: return chk[0];
      default:                  return 1'b1;
    endcase
  endfunction : perm_fault

  task automatic wrap_up;
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : wrap_up

  task automatic fill(input logic [3:0] idx, input logic [19:0] vpn,
                      input logic [7:0] address_space_identifier, input logic [19:0] ppn,
                      input logic [2:0] ap, input logic g, lk);
    @(posedge clk);
    #1;
    {fill_valid, fill_index, fill_vpn, fill_address_space_identifier} = {1'b1, idx, vpn, address_space_identifier};
    {fill_ppn, fill_ap, fill_global, fill_lock} = {ppn, ap, g, lk};
    @(posedge clk);
    #1;
    fill_valid = 1'b0;
  endtask : fill

  task automatic cmd(input logic wr, input logic [3:0] crn, minor_register_field,
                     input logic [2:0] op2, input logic [31:0] d,
                     input logic pv, input logic [1:0] ea);
    logic [1:0] ans;
    core.issue(wr, crn, minor_register_field, op2, d, pv, ans);
    `CHK("answer", ea, ans)
    if (ans === 2'h0) wrap_up();
  endtask : cmd

  // Expected result: page on hit, zero page and fault on miss
  task automatic probe(input logic [19:0] vpn, input logic [7:0] ctx,
                       input logic [2:0] op2, input logic hit,
                       input logic [19:0] ppn, input logic [2:0] ap);
    context_address_space_identifier = ctx;
    exp_pa = hit ? {ppn, perm_fault(ap, op2[1:0])} : {20'h0, 1'b1};
    cmd(1'b1, CRN_CACHE, CRM_TRANSLATE, op2, {vpn, 12'h0}, 1'b1, 2'h1);
    `CHK("result", exp_pa, {pa_result[31:12], pa_result[0]})
  endtask : probe

  function automatic logic [19:0] vpn_of(input int k);
    return {16'h3c5a, 4'(k)};
  endfunction : vpn_of

  function automatic logic [7:0] address_space_identifier_of(input int k);
    return (k == 3) ? 8'h47 : 8'h21;
  endfunction : address_space_identifier_of

  initial begin
    {reset_n, secure, irq, fill_valid, fill_index, fill_vpn} = '0;
    {fill_address_space_identifier, fill_ppn, fill_ap, fill_global, fill_lock} = '0;
    {context_address_space_identifier, bad_count, n_compared, bcast_cnt} = '0;
    seed = 32'h32ca;
    repeat (12) @(posedge clk);
    #1;
    reset_n = 1'b1;
    repeat (24) begin
      repeat (7) seed = lfsr(seed);
      secure = seed[4];
      fill(4'h0, seed[31:12], seed[7:0], seed[27:8], seed[10:8], seed[11], 1'b0);
      probe(seed[31:12], seed[3] ? seed[7:0] : ~seed[7:0], seed[14:12],
            seed[11] | seed[3], seed[27:8], seed[10:8]);
      cmd(1'b0, CRN_CACHE, CRM_RESULT, OP2_RESULT, 32'h0, 1'b1, 2'h1);
      `CHK("rdata", exp_pa, {cp_rdata[31:12], cp_rdata[0]})
    end
    cmd(1'b1, CRN_CACHE, CRM_TRANSLATE, 3'h0, 32'h0, 1'b0, 2'h2);
    `CHK("held", exp_pa, {pa_result[31:12], pa_result[0]})
    cmd(1'b0, CRN_MAINT, CRM_UTLB, OP2_INV_ALL, 32'h0, 1'b1, 2'h2);
    cmd(1'b1, CRN_MAINT, CRM_UTLB, OP2_INV_ALL, 32'h0, 1'b0, 2'h2);
    // Only defined selector and minor field pairs are sent
    foreach (CRMS[c]) begin
      for (int t = 0; t < 5; t++) begin
        for (int k = 0; k < 4; k++)
          fill(4'(k), vpn_of(k), address_space_identifier_of(k), {16'h9e10, 4'(k)}, AP_FULL,
               k == 2, k == 1);
        opnd = (t == 0) ? 32'h0 : {vpn_of(T_K[t]), 4'h0, address_space_identifier_of(T_K[t])};
        b0 = bcast_cnt;
        cmd(1'b1, CRN_MAINT, CRMS[c], T_OP[t], opnd, 1'b1, 2'h1);
        // Pulse counter only ticks on the edge after the pulse rises
        @(posedge clk);
        #1;
        `CHK("bcast", CRMS[c] == CRM_BCAST, bcast_cnt - b0 == 1)
        if (CRMS[c] == CRM_BCAST)
          `CHK("bcast op", {T_OP[t], opnd}, {bcast_op, bcast_data})
        for (int k = 0; k < 4; k++)
          probe(vpn_of(k), address_space_identifier_of(k), 3'h0, T_KEEP[t][k],
                {16'h9e10, 4'(k)}, AP_FULL);
      end
    end
    fork
      cmd(1'b1, CRN_MAINT, CRM_UTLB, OP2_INV_SPACE, 32'h21, 1'b1, 2'h3);
      begin
        repeat (4) @(posedge clk);
        #1;
        irq = 1'b1;
      end
    join
    irq = 1'b0;
    // Entry loaded while the interrupt is serviced
    fill(4'h5, vpn_of(5), 8'h21, 20'h9e155, AP_FULL, 1'b0, 1'b0);
    cmd(1'b1, CRN_MAINT, CRM_UTLB, OP2_INV_SPACE, 32'h21, 1'b1, 2'h1);
    probe(vpn_of(0), 8'h21, 3'h0, 1'b0, 20'h0, AP_FULL);
    probe(vpn_of(5), 8'h21, 3'h0, 1'b0, 20'h0, AP_FULL);
    probe(vpn_of(2), 8'h21, 3'h0, 1'b1, 20'h9e102, AP_FULL);
    wrap_up();
  end
endmodule : tlb_maintenance_and_va_translate_tb
